// ### hdl/svm_ctrl.sv
// Purpose: walks the device's supply monitor setup and status reads on command
// Assumes: sole master of the device register pins; commands come from the same clock
// Notes:   every protected write is preceded by its own unlock write
`timescale 1ns/1ps
//
// Contract
// R1: no level-0 status; such reads refused
// R2: level-1 status only after enable and settle
// R3: level-2 status only after enable and settle
// R4: monitor-0 stop exit needs filter disabled
// R5: monitor-1 stop exit needs filter disabled
// R6: monitor-0: enable circuit, wait settle first
// R7: filtered monitor-0: divider, then filter enabled
// R8: unfiltered monitor-0: edge select one, filter off
// R9: monitor-0 mode select always reset
// R10: clear monitor-0 pass flag before enabling
// R11: filter use: start slow oscillator first; code starts it after the filter config and flag clear writes
// R12: filter use: wait four sampling clocks
// R13: monitor-0 last step sets reset enable
// R14: timing, filter, mode in one write
// R15: monitor-1: enable circuit, wait settle first
// R16: filtered monitor-1: divider, filter enabled
// R17: unfiltered monitor-1 reset needs edge one
// R18: monitor-1 mode: zero interrupt, one reset
// R19: clear monitor-1 pass flag before enabling
// R20: monitor-1 last step sets enable
// R21: filtered: both crossing directions interrupt
// R22: unfiltered: one direction via edge select
// R23: pass flag cleared by zero; one keeps
// R24: writes ignored unless unlock bit set
// R25: filter accepts only stable comparator output
module svm_ctrl
  import svm_pkg::*;
#(
  parameter int SETTLE_NS     = 100000,
  parameter int OSC_PERIOD_NS = 8000,
  parameter int TMR_W         = 24
) (
  // clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              NRST,
  // command
  input  wire logic              CMD_VALID,
  output logic                   CMD_READY,
  input  wire svm_pkg::svm_cmd_t CMD_CODE,
  input  wire logic              CFG_FILTER,
  input  wire logic [1:0]        CFG_DIV,
  input  wire logic              CFG_RESET_MODE,
  input  wire logic              CFG_EDGE,
  // result
  output logic                   BUSY,
  output logic                   DONE,
  output logic                   REFUSED,
  output logic                   STAT_VALID,
  output logic                   STAT_ABOVE,
  output logic [2:0]             LEVEL_READY,
  // device register pins
  output logic [7:0]             DEV_ADDR,
  output logic [7:0]             DEV_WDATA,
  output logic                   DEV_WE,
  output logic                   DEV_RE,
  input  wire logic [7:0]        DEV_RDATA
);
  import svm_pkg::*;

  localparam int SETTLE_CYC_I  = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_CYC_I     = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLT_BASE_I    = FLT_SAMPLES * OSC_CYC_I;
  localparam int FLT_MAX_I     = FLT_BASE_I * 8;
  localparam logic [TMR_W-1:0] SETTLE_CYC = TMR_W'(SETTLE_CYC_I);
  localparam logic [TMR_W-1:0] FLT_BASE   = TMR_W'(FLT_BASE_I);

  if (SETTLE_NS < 1 || OSC_PERIOD_NS < 1 || TMR_W > 31) begin : g_bad_time
    $error("svm_ctrl: times must be positive and TMR_W below 32");
  end
  if (SETTLE_CYC_I >= (1 << TMR_W) || FLT_MAX_I >= (1 << TMR_W)) begin : g_bad_width
    $error("svm_ctrl: TMR_W too small for the wait counts");
  end

  svm_state_t        state_q;
  svm_step_t         step_q;
  svm_cmd_t          cmd_q;
  logic              flt_q;
  logic [DIV_W-1:0]  div_q;
  logic              rst_mode_q;
  logic              edge_q;
  logic [2:0]        det_en_q;
  logic [2:0]        settled_q;
  logic              done_q;
  logic              refused_q;
  logic              stat_valid_q;
  logic              stat_above_q;

  logic [1:0]        lvl;
  logic [2:0]        lvl_mask;
  logic              is_mon1;
  logic              rd_ok;
  logic [DATA_W-1:0] mon_word;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] rd_addr;
  logic              tmr_load;
  logic [TMR_W-1:0]  tmr_val;
  logic              tmr_expire;

  svm_acc_if acc ();

  svm_reg_port u_port (
    .clk       (CLK_SYS),
    .nrst      (NRST),
    .acc       (acc),
    .dev_addr  (DEV_ADDR),
    .dev_wdata (DEV_WDATA),
    .dev_we    (DEV_WE),
    .dev_re    (DEV_RE),
    .dev_rdata (DEV_RDATA)
  );

  svm_wait_timer #(.W(TMR_W)) u_tmr (
    .clk      (CLK_SYS),
    .nrst     (NRST),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expire   (tmr_expire)
  );

  assign CMD_READY   = (state_q == S_IDLE);
  assign BUSY        = (state_q != S_IDLE);
  assign DONE        = done_q;
  assign REFUSED     = refused_q;
  assign STAT_VALID  = stat_valid_q;
  assign STAT_ABOVE  = stat_above_q;
  assign LEVEL_READY = settled_q;

  // which detection level the latched command concerns
  always_comb begin
    case (cmd_q)
      CMD_SETUP_MON0:  lvl = 2'h0;
      CMD_SETUP_MON1:  lvl = 2'h1;
      CMD_READ_LVL1:   lvl = 2'h1;
      default:         lvl = 2'h2;
    endcase
  end

  assign lvl_mask = 3'h1 << lvl;
  assign is_mon1  = (cmd_q == CMD_SETUP_MON1);

  // monitor control word, built per step
  always_comb begin
    mon_word = '0;
    // R7 divider choice
    mon_word[BIT_DIV_LO +: DIV_W] = div_q;
    // R4 R21 R25 filter off when unfiltered
    mon_word[BIT_FLT_DIS] = !flt_q;
    // R9 monitor-0 reset mode
    mon_word[BIT_MODE] = 1'b1;
    if (is_mon1) begin
      // R18 mode choice
      mon_word[BIT_MODE] = rst_mode_q;
    end
    // R22 edge only meaningful unfiltered
    if (!flt_q) begin
      // R8 monitor-0 edge one
      mon_word[BIT_EDGE] = 1'b1;
      if (is_mon1) begin
        // R17 reset forces edge one
        mon_word[BIT_EDGE] = rst_mode_q ? 1'b1 : edge_q;
      end
    end
    // R23 one leaves flag untouched
    mon_word[BIT_PASS] = (step_q != ST_CLR);
    // R13 enable only in final step
    mon_word[BIT_MON_EN] = (step_q == ST_FIN);
  end

  // address and data of the protected write for each step
  always_comb begin
    wr_addr = is_mon1 ? ADR_MON1_CTRL : ADR_MON0_CTRL;
    wr_data = mon_word;
    case (step_q)
      ST_EN: begin
        wr_addr = ADR_DET_CTRL_TWO;
        wr_data = DATA_W'(det_en_q | lvl_mask) << BIT_DET0_EN;
      end
      ST_OSC: begin
        wr_addr = ADR_CLK_MODE_ONE;
        // R11 slow oscillator on
        wr_data = CLK_MODE_BASE & ~(DATA_W'(1) << BIT_OSC_STOP);
      end
      default: begin
        wr_addr = is_mon1 ? ADR_MON1_CTRL : ADR_MON0_CTRL;
        wr_data = mon_word;
      end
    endcase
  end

  assign rd_addr = (cmd_q == CMD_READ_LVL1) ? ADR_MON1_CTRL : ADR_DET_CTRL_ONE;

  // access request toward the pin engine
  always_comb begin
    acc.req   = 1'b0;
    acc.we    = 1'b1;
    acc.addr  = wr_addr;
    acc.wdata = wr_data;
    case (state_q)
      S_UNLK: begin
        // R24 unlock before each write
        acc.req   = 1'b1;
        acc.addr  = ADR_PROTECT;
        acc.wdata = DATA_W'(1) << BIT_UNLOCK;
      end
      S_WR: begin
        acc.req = 1'b1;
      end
      S_RD: begin
        acc.req  = 1'b1;
        acc.we   = 1'b0;
        acc.addr = rd_addr;
      end
      default: begin
        acc.req = 1'b0;
      end
    endcase
  end

  // wait loads: settle after circuit enable, filter wait after oscillator start
  always_comb begin
    tmr_load = 1'b0;
    tmr_val  = SETTLE_CYC;
    if (state_q == S_WR && acc.done) begin
      if (step_q == ST_EN) begin
        // R6 settle after circuit enable
        tmr_load = 1'b1;
      end else if (step_q == ST_OSC) begin
        // R12 four sampling periods
        tmr_load = 1'b1;
        tmr_val  = FLT_BASE << div_q;
      end
    end
  end

  // R2 level-1 read gate
  // R3 level-2 read gate
  always_comb begin
    case (CMD_CODE)
      CMD_READ_LVL1: rd_ok = settled_q[1];
      CMD_READ_LVL2: rd_ok = settled_q[2];
      default:       rd_ok = 1'b0;
    endcase
  end

  // sequencer
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (CMD_VALID) begin
            case (CMD_CODE)
              CMD_SETUP_MON0, CMD_SETUP_MON1, CMD_ENABLE_LVL2: state_q <= S_UNLK;
              CMD_READ_LVL1, CMD_READ_LVL2: state_q <= rd_ok ? S_RD : S_IDLE;
              // R1 level-0 read refused
              default: state_q <= S_IDLE;
            endcase
          end
        end
        S_UNLK: begin
          if (acc.done) begin
            state_q <= S_WR;
          end
        end
        S_WR: begin
          if (acc.done) begin
            case (step_q)
              ST_EN, ST_OSC: state_q <= S_WAIT;
              ST_FIN:        state_q <= S_FIN;
              default:       state_q <= S_UNLK;
            endcase
          end
        end
        S_WAIT: begin
          if (tmr_expire) begin
            state_q <= (cmd_q == CMD_ENABLE_LVL2) ? S_FIN : S_UNLK;
          end
        end
        S_RD: begin
          if (acc.done) begin
            state_q <= S_FIN;
          end
        end
        S_FIN: begin
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // step order of a monitor setup
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      step_q <= ST_EN;
    end else if (state_q == S_IDLE) begin
      // R15 circuit enable first
      step_q <= ST_EN;
    end else if (state_q == S_WR && acc.done) begin
      case (step_q)
        // R14 config in one write
        ST_CFG: step_q <= ST_CLR;
        // R10 flag cleared before enable
        // R19 flag cleared before enable
        ST_CLR: step_q <= flt_q ? ST_OSC : ST_FIN;
        default: step_q <= step_q;
      endcase
    end else if (state_q == S_WAIT && tmr_expire) begin
      // R16 filter setup after settle
      // R20 final enable after filter wait
      step_q <= (step_q == ST_EN) ? ST_CFG : ST_FIN;
    end
  end

  // command latch
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      cmd_q      <= CMD_SETUP_MON0;
      flt_q      <= 1'b0;
      div_q      <= '0;
      rst_mode_q <= 1'b0;
      edge_q     <= 1'b0;
    end else if (CMD_VALID && state_q == S_IDLE) begin
      cmd_q      <= CMD_CODE;
      // R5 stop exit only unfiltered
      flt_q      <= CFG_FILTER;
      div_q      <= CFG_DIV;
      rst_mode_q <= CFG_RESET_MODE;
      edge_q     <= CFG_EDGE;
    end
  end

  // circuit enable shadow and settle tracking
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      det_en_q  <= '0;
      settled_q <= '0;
    end else begin
      if (state_q == S_WR && acc.done && step_q == ST_EN) begin
        det_en_q <= det_en_q | lvl_mask;
      end
      if (state_q == S_WAIT && tmr_expire && step_q == ST_EN) begin
        settled_q <= settled_q | lvl_mask;
      end
    end
  end

  // results
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      done_q       <= 1'b0;
      refused_q    <= 1'b0;
      stat_valid_q <= 1'b0;
      stat_above_q <= 1'b0;
    end else begin
      done_q    <= (state_q == S_FIN);
      refused_q <= 1'b0;
      if (CMD_VALID && state_q == S_IDLE) begin
        stat_valid_q <= 1'b0;
        case (CMD_CODE)
          CMD_SETUP_MON0, CMD_SETUP_MON1, CMD_ENABLE_LVL2: refused_q <= 1'b0;
          default: refused_q <= !rd_ok;
        endcase
      end
      if (state_q == S_RD && acc.done) begin
        stat_valid_q <= 1'b1;
        stat_above_q <= (cmd_q == CMD_READ_LVL1) ? acc.rdata[BIT_L1_STAT] : acc.rdata[BIT_L2_STAT];
      end
    end
  end

endmodule

// ### hdl/svm_pkg.sv
// Purpose: shared constants and types of the supply monitor setup controller
// Assumes: 8-bit register interface of the monitored device, 50 MHz system clock
// Notes:   offsets and bit positions are the device's register map as seen from outside
package svm_pkg;

  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 8;

  // device register offsets
  localparam logic [ADDR_W-1:0] ADR_PROTECT      = 8'h0A;
  localparam logic [ADDR_W-1:0] ADR_CLK_MODE_ONE = 8'h07;
  localparam logic [ADDR_W-1:0] ADR_DET_CTRL_ONE = 8'h31;
  localparam logic [ADDR_W-1:0] ADR_DET_CTRL_TWO = 8'h32;
  localparam logic [ADDR_W-1:0] ADR_MON1_CTRL    = 8'h36;
  localparam logic [ADDR_W-1:0] ADR_MON0_CTRL    = 8'h38;

  // field positions
  localparam int BIT_UNLOCK   = 3;
  localparam int BIT_DET0_EN  = 5;
  localparam int BIT_MON_EN   = 0;
  localparam int BIT_FLT_DIS  = 1;
  localparam int BIT_PASS     = 2;
  localparam int BIT_L1_STAT  = 3;
  localparam int BIT_DIV_LO   = 4;
  localparam int BIT_MODE     = 6;
  localparam int BIT_EDGE     = 7;
  localparam int BIT_L2_STAT  = 3;
  localparam int BIT_OSC_STOP = 4;
  localparam int DIV_W        = 2;

  // value written to the clock mode register, slow oscillator stop bit cleared
  localparam logic [DATA_W-1:0] CLK_MODE_BASE = 8'h00;

  // filter settles after this many sampling clock periods
  localparam int FLT_SAMPLES = 4;
  // cycles from read strobe to capture: two sync stages plus one margin
  localparam logic [3:0] RD_LAT = 4'h3;

  typedef enum logic [2:0] {
    CMD_SETUP_MON0  = 3'h0,
    CMD_SETUP_MON1  = 3'h1,
    CMD_ENABLE_LVL2 = 3'h2,
    CMD_READ_LVL0   = 3'h3,
    CMD_READ_LVL1   = 3'h4,
    CMD_READ_LVL2   = 3'h5
  } svm_cmd_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_UNLK = 6'h02,
    S_WR   = 6'h04,
    S_WAIT = 6'h08,
    S_RD   = 6'h10,
    S_FIN  = 6'h20
  } svm_state_t;

  typedef enum logic [4:0] {
    ST_EN  = 5'h01,
    ST_CFG = 5'h02,
    ST_CLR = 5'h04,
    ST_OSC = 5'h08,
    ST_FIN = 5'h10
  } svm_step_t;

endpackage

// ### hdl/svm_acc_if.sv
// Purpose: carries one register access between sequencer and pin engine
// Assumes: req held until done pulses; done is one cycle
// Notes:   rdata is valid in the cycle of done
`timescale 1ns/1ps
interface svm_acc_if;
  import svm_pkg::*;
  logic              req;
  logic              we;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              done;
  logic [DATA_W-1:0] rdata;

  modport ctrl (output req, output we, output addr, output wdata, input done, input rdata);
  modport port (input req, input we, input addr, input wdata, output done, output rdata);
endinterface

// ### hdl/svm_wait_timer.sv
// Purpose: down counter for settling and filter waits
// Assumes: load value at least one
// Notes:   expire pulses once, load value cycles after load
`timescale 1ns/1ps
module svm_wait_timer #(
  parameter int W = 24
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // status
  output logic              expire
);
  logic [W-1:0] cnt_q;
  logic         run_q;

  assign expire = run_q && (cnt_q == W'(1));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (load) begin
      cnt_q <= load_val;
      run_q <= 1'b1;
    end else if (run_q) begin
      cnt_q <= cnt_q - W'(1);
      if (cnt_q == W'(1)) begin
        run_q <= 1'b0;
      end
    end
  end
endmodule

// ### hdl/svm_reg_port.sv
// Purpose: drives the device register pins for one access at a time
// Assumes: device takes a write on a one-cycle strobe; read data follows the held address
// Notes:   read data arrives from another domain, so it is synchronised first
`timescale 1ns/1ps
module svm_reg_port
  import svm_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // sequencer side
  svm_acc_if.port                acc,
  // device pins
  output logic [ADDR_W-1:0]      dev_addr,
  output logic [DATA_W-1:0]      dev_wdata,
  output logic                   dev_we,
  output logic                   dev_re,
  input  wire logic [DATA_W-1:0] dev_rdata
);
  logic [DATA_W-1:0] sync1_q;
  logic [DATA_W-1:0] sync2_q;
  logic [DATA_W-1:0] rdata_q;
  logic [3:0]        cnt_q;
  logic              busy_q;
  logic              done_q;

  assign acc.done  = done_q;
  assign acc.rdata = rdata_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= dev_rdata;
      sync2_q <= sync1_q;
    end
  end

  // done cycle blocks a new accept so a stale req is never taken twice
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dev_addr  <= '0;
      dev_wdata <= '0;
      dev_we    <= 1'b0;
      dev_re    <= 1'b0;
      cnt_q     <= '0;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      rdata_q   <= '0;
    end else begin
      dev_we <= 1'b0;
      dev_re <= 1'b0;
      done_q <= 1'b0;
      if (acc.req && !busy_q && !done_q) begin
        dev_addr  <= acc.addr;
        dev_wdata <= acc.wdata;
        dev_we    <= acc.we;
        dev_re    <= !acc.we;
        cnt_q     <= acc.we ? 4'h0 : RD_LAT;
        busy_q    <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == 4'h0) begin
          busy_q  <= 1'b0;
          done_q  <= 1'b1;
          rdata_q <= sync2_q;
        end else begin
          cnt_q <= cnt_q - 4'h1;
        end
      end
    end
  end
endmodule

// ### dv/svm_ctrl_chk.sv
// Purpose: port-level assertions for the supply monitor setup controller
// Assumes: one clock domain, synchronous active-low reset
// Notes:   helper flags follow the write stream seen on the device pins
`timescale 1ns/1ps
module svm_ctrl_chk (
  // clock and reset
  input wire logic              CLK_SYS,
  input wire logic              NRST,
  // command
  input wire logic              CMD_VALID,
  input wire logic              CMD_READY,
  input wire svm_pkg::svm_cmd_t CMD_CODE,
  input wire logic              DONE,
  input wire logic              REFUSED,
  input wire logic [2:0]        LEVEL_READY,
  // device pins
  input wire logic [7:0]        DEV_ADDR,
  input wire logic [7:0]        DEV_WDATA,
  input wire logic              DEV_WE,
  input wire logic              DEV_RE
);
  import svm_pkg::*;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  logic take;
  logic unlk_q;
  logic clr0_q;
  assign take = CMD_VALID && CMD_READY;
  // unlock lapses after any other write, so each protected write needs its own
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      unlk_q <= 1'b0;
    end else if (DEV_WE) begin
      unlk_q <= DEV_ADDR == ADR_PROTECT && DEV_WDATA[BIT_UNLOCK];
    end
  end
  // pass flag clear seen since the circuit enable write
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      clr0_q <= 1'b0;
    end else if (DEV_WE && DEV_ADDR == ADR_DET_CTRL_TWO) begin
      clr0_q <= 1'b0;
    end else if (DEV_WE && DEV_ADDR == ADR_MON0_CTRL && !DEV_WDATA[BIT_PASS]) begin
      clr0_q <= 1'b1;
    end
  end
  lvl0_refuse_a: assert property (take && CMD_CODE == CMD_READ_LVL0 |=> REFUSED && !DONE)
    else $error("level 0 read not refused");
  pins_quiet_a: assert property (take && CMD_CODE == CMD_READ_LVL0 |=> (!DEV_RE && !DEV_WE) [*3])
    else $error("refused command touched the pins");
  lvl1_gate_a: assert property (take && CMD_CODE == CMD_READ_LVL1 && !LEVEL_READY[1] |=> REFUSED)
    else $error("level 1 read before settle not refused");
  lvl2_gate_a: assert property (take && CMD_CODE == CMD_READ_LVL2 && !LEVEL_READY[2] |=> REFUSED)
    else $error("level 2 read before settle not refused");
  lvl1_read_a: assert property (take && CMD_CODE == CMD_READ_LVL1 && LEVEL_READY[1]
    |-> ##2 DEV_RE && DEV_ADDR == ADR_MON1_CTRL)
    else $error("level 1 read strobe misplaced");
  read_done_a: assert property (DEV_RE |-> ##6 DONE)
    else $error("read did not finish on time");
  unlock_first_a: assert property (DEV_WE && DEV_ADDR != ADR_PROTECT |-> unlk_q)
    else $error("protected write without unlock");
  mon0_reset_a: assert property (DEV_WE && DEV_ADDR == ADR_MON0_CTRL |-> DEV_WDATA[BIT_MODE])
    else $error("monitor 0 not in reset mode");
  mon0_edge_a: assert property (DEV_WE && DEV_ADDR == ADR_MON0_CTRL && DEV_WDATA[BIT_FLT_DIS]
    |-> DEV_WDATA[BIT_EDGE])
    else $error("monitor 0 unfiltered edge not one");
  mon1_edge_a: assert property (DEV_WE && DEV_ADDR == ADR_MON1_CTRL && DEV_WDATA[BIT_MODE] && DEV_WDATA[BIT_FLT_DIS]
    |-> DEV_WDATA[BIT_EDGE])
    else $error("monitor 1 reset edge not one");
  mon0_clear_a: assert property (DEV_WE && DEV_ADDR == ADR_MON0_CTRL && DEV_WDATA[BIT_MON_EN] |-> clr0_q)
    else $error("monitor 0 enabled before flag clear");
endmodule
bind svm_ctrl svm_ctrl_chk svm_ctrl_chk_inst (.CLK_SYS(CLK_SYS), .NRST(NRST), .CMD_VALID(CMD_VALID),
  .CMD_READY(CMD_READY), .CMD_CODE(CMD_CODE), .DONE(DONE), .REFUSED(REFUSED), .LEVEL_READY(LEVEL_READY),
  .DEV_ADDR(DEV_ADDR), .DEV_WDATA(DEV_WDATA), .DEV_WE(DEV_WE), .DEV_RE(DEV_RE));

// ### dv/svm_dev_model.sv
// Purpose: behavioural model of the monitored device registers
// Assumes: oscillator stopped out of reset; unlock lapses after one write
// Notes:   settle delays are not modelled, the controller must wait itself
`timescale 1ns/1ps
module svm_dev_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // register pins
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       we,
  output logic [7:0]      rdata,
  // analog side
  input  wire logic       above1,
  input  wire logic       above2,
  input  wire logic       pass_evt,
  // register view
  output logic [7:0]      det_two_q,
  output logic [7:0]      clk_mode_q,
  output logic [7:0]      mon0_q,
  output logic [7:0]      mon1_q
);
  import svm_pkg::*;
  logic unlk_q;
  logic wr;
  assign wr = we && addr != ADR_PROTECT && unlk_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      unlk_q <= 1'b0;
    end else if (we) begin
      unlk_q <= addr == ADR_PROTECT && wdata[BIT_UNLOCK];
    end
  end
  // whole config in one write, flag cleared by zero only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      det_two_q  <= 8'h00;
      clk_mode_q <= 8'h10;
      mon0_q     <= 8'h00;
      mon1_q     <= 8'h00;
    end else begin
      if (wr && addr == ADR_DET_CTRL_TWO) det_two_q <= wdata;
      if (wr && addr == ADR_CLK_MODE_ONE) clk_mode_q <= wdata;
      if (wr && addr == ADR_MON0_CTRL) mon0_q <= {wdata[7:3], wdata[2] & mon0_q[2], wdata[1:0]};
      if (wr && addr == ADR_MON1_CTRL) mon1_q <= {wdata[7:4], 1'b0, wdata[2] & mon1_q[2], wdata[1:0]};
      if (pass_evt) begin
        mon0_q[BIT_PASS] <= 1'b1;
        mon1_q[BIT_PASS] <= 1'b1;
      end
    end
  end
  // status only for levels 1 and 2; level 2 reads one while off
  always_comb begin
    case (addr)
      ADR_DET_CTRL_ONE: rdata = {4'h0, det_two_q[7] ? above2 : 1'b1, 3'h0};
      ADR_DET_CTRL_TWO: rdata = det_two_q;
      ADR_MON1_CTRL:    rdata = {mon1_q[7:4], det_two_q[6] & above1, mon1_q[2:0]};
      ADR_MON0_CTRL:    rdata = mon0_q;
      default:          rdata = 8'hA5;
    endcase
  end
endmodule

// ### dv/svm_ctrl_tb_top.sv
// Purpose: self-checking bench of the supply monitor setup controller
// Assumes: short settle and oscillator periods so waits stay small
// Notes:   expected register images and wait spans are worked out here
`timescale 1ns/1ps
module svm_ctrl_tb_top;
  import svm_pkg::*;
  localparam int SET_CYC = 10;
  localparam int OSC_CYC = 5;
  logic       clk_sys = 1'b0;
  logic       nrst = 1'b0;
  logic       cmd_valid = 1'b0;
  svm_cmd_t   cmd_code = CMD_SETUP_MON0;
  logic       cfg_filter = 1'b0;
  logic [1:0] cfg_div = 2'h0;
  logic       cfg_reset_mode = 1'b0;
  logic       cfg_edge = 1'b0;
  logic       above1 = 1'b0;
  logic       above2 = 1'b0;
  logic       pass_evt = 1'b0;
  logic       cmd_ready, busy, done, refused, stat_valid, stat_above, dev_we, dev_re, rf;
  logic [2:0] level_ready;
  logic [7:0] dev_addr, dev_wdata, dev_rdata, det_two, clk_mode, mon0, mon1, exp_v, mask;
  // seed 84257
  logic [31:0] lfsr = 32'h00014921;
  int         fails = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         t_det = 0;
  int         t_cfg = 0;
  int         t_osc = 0;
  int         t_en = 0;
  svm_cmd_t   bad [5] = '{CMD_READ_LVL0, CMD_READ_LVL1, CMD_READ_LVL2, svm_cmd_t'(3'h6), svm_cmd_t'(3'h7)};

  always #10 clk_sys = ~clk_sys;

  svm_ctrl #(.SETTLE_NS(200), .OSC_PERIOD_NS(100)) svm_ctrl_inst (.CLK_SYS(clk_sys), .NRST(nrst),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_CODE(cmd_code), .CFG_FILTER(cfg_filter),
    .CFG_DIV(cfg_div), .CFG_RESET_MODE(cfg_reset_mode), .CFG_EDGE(cfg_edge), .BUSY(busy), .DONE(done),
    .REFUSED(refused), .STAT_VALID(stat_valid), .STAT_ABOVE(stat_above), .LEVEL_READY(level_ready),
    .DEV_ADDR(dev_addr), .DEV_WDATA(dev_wdata), .DEV_WE(dev_we), .DEV_RE(dev_re), .DEV_RDATA(dev_rdata));

  svm_dev_model svm_dev_model_inst (.clk(clk_sys), .nrst(nrst), .addr(dev_addr), .wdata(dev_wdata),
    .we(dev_we), .rdata(dev_rdata), .above1(above1), .above2(above2), .pass_evt(pass_evt),
    .det_two_q(det_two), .clk_mode_q(clk_mode), .mon0_q(mon0), .mon1_q(mon1));

  // write stream timestamps, used to measure the waits between steps
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (dev_we && dev_addr == ADR_DET_CTRL_TWO) t_det <= cyc;
    if (dev_we && dev_addr == ADR_CLK_MODE_ONE) t_osc <= cyc;
    if (dev_we && (dev_addr == ADR_MON0_CTRL || dev_addr == ADR_MON1_CTRL)) begin
      if (t_cfg <= t_det) t_cfg <= cyc;
      if (dev_wdata[BIT_MON_EN]) t_en <= cyc;
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one command, then wait for its finish or refusal under a bound
  task automatic run(input svm_cmd_t c, input logic f, input logic [1:0] d, input logic rm, input logic e);
    int n;
    n = 0;
    cmd_code <= c;
    cfg_filter <= f;
    cfg_div <= d;
    cfg_reset_mode <= rm;
    cfg_edge <= e;
    cmd_valid <= 1'b1;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    while (n < 5000) begin
      @(negedge clk_sys);
      if (done === 1'b1 || refused === 1'b1) break;
      n++;
    end
    rf = refused;
    if (n >= 5000) begin
      fails++;
      stop_test();
    end
    @(posedge clk_sys);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    stop_test();
  end

  initial begin
    logic m1;
    logic f;
    logic rm;
    logic [1:0] d;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++) begin
      run(bad[i], 1'b0, 2'h0, 1'b0, 1'b0);
      check("refused", 8'h01, {7'h0, rf});
    end
    // cases 0..2 monitor 0, 3..6 monitor 1; the first of monitor 0 and the first two of monitor 1 unfiltered
    for (int i = 0; i < 7; i++) begin
      lfsr = lfsr_next(lfsr);
      m1 = i >= 3;
      f = m1 ? ((i - 3) >> 1) : (i > 0);
      rm = m1 ? ((i - 3) & 1) : 1'b1;
      d = lfsr[1:0];
      pass_evt <= 1'b1;
      @(posedge clk_sys);
      pass_evt <= 1'b0;
      run(m1 ? CMD_SETUP_MON1 : CMD_SETUP_MON0, f, d, rm, lfsr[2]);
      mask = f ? 8'h77 : 8'hC7;
      exp_v = f ? {1'b0, rm, d, 4'h1} : {rm | lfsr[2], rm, 6'h03};
      check("monitor ctrl", exp_v, (m1 ? mon1 : mon0) & mask);
      check("settle wait", 8'h01, {7'h0, t_cfg - t_det >= SET_CYC});
      check("level ready", 8'h01, {7'h0, level_ready[m1]});
      if (f) begin
        check("filter wait", 8'h01, {7'h0, t_en - t_osc >= 4 * OSC_CYC * (1 << d)});
      end
      // oscillator must stay stopped until a filtered setup needs it
      check("osc stop", (i == 0) ? 8'h10 : 8'h00, clk_mode & 8'h10);
    end
    run(CMD_ENABLE_LVL2, 1'b0, 2'h0, 1'b0, 1'b0);
    check("level2 ready", 8'h01, {7'h0, level_ready[2]});
    for (int k = 0; k < 6; k++) begin
      lfsr = lfsr_next(lfsr);
      above1 <= lfsr[0];
      above2 <= lfsr[1];
      run(k[0] ? CMD_READ_LVL2 : CMD_READ_LVL1, 1'b0, 2'h0, 1'b0, 1'b0);
      check("status", {6'h0, 1'b1, k[0] ? above2 : above1}, {6'h0, stat_valid, stat_above});
      check("busy", 8'h00, {7'h0, busy});
    end
    stop_test();
  end
endmodule
